// *** src/dwd_pkg.sv ***
// shared constants and types of the digital watchdog
package dwd_pkg;
   localparam logic [7:0] DWD_REG_OFFSET  = 8'hD8;
   localparam logic [7:0] DWD_RESET_VAL   = 8'hFE;
   localparam int         DWD_ACT_BIT     = 0;
   localparam int         DWD_SR_BIT      = 1;
   localparam int         DWD_PERIOD_LSB  = 2;
   localparam int         DWD_PERIOD_W    = 6;
   localparam int         DWD_CNT_W       = 7;
   localparam logic [6:0] DWD_CNT_RESET   = 7'h7F;
   localparam logic [6:0] DWD_CNT_SR_EDGE = 7'h40;
   localparam int         DWD_PRE_DIV_A   = 12;
   localparam int         DWD_PRE_DIV_B   = 256;
   localparam int         DWD_STAB_CYCLES = 2048;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } dwd_bus_t;

   typedef enum logic [1:0] {
      DWD_RUN,
      DWD_WAIT,
      DWD_STOP
   } dwd_pwr_t;
endpackage

// *** src/dwd_prescaler.sv ***
// two-stage oscillator prescaler producing the counter tick
`timescale 1ns/100ps
module dwd_prescaler
   import dwd_pkg::*;
#(
   parameter int DIV_A = DWD_PRE_DIV_A,
   parameter int DIV_B = DWD_PRE_DIV_B
) (
   input  wire logic clk_in,
   input  wire logic resetn_in,
   input  wire logic restart_in,
   output logic      tick_out
);
   localparam int AW = $clog2(DIV_A);
   localparam int BW = $clog2(DIV_B);

   logic [AW-1:0] a_r;
   logic [BW-1:0] b_r;
   wire           a_end = (a_r == AW'(DIV_A - 1));
   wire           b_end = (b_r == BW'(DIV_B - 1));

   assign tick_out = a_end & b_end;

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         a_r <= '0;
         b_r <= '0;
      end else if (restart_in) begin
         a_r <= '0;
         b_r <= '0;
      end else if (a_end) begin
         a_r <= '0;
         b_r <= b_end ? '0 : b_r + 1'b1;
      end else begin
         a_r <= a_r + 1'b1;
      end
   end
endmodule

// *** src/dwd_stab_delay.sv ***
// holds the chip reset through the stabilisation delay
`timescale 1ns/100ps
module dwd_stab_delay
   import dwd_pkg::*;
#(
   parameter int CYCLES = DWD_STAB_CYCLES
) (
   input  wire logic clk_in,
   input  wire logic resetn_in,
   input  wire logic trigger_in,
   output logic      hold_out
);
   localparam int CW = $clog2(CYCLES + 1);

   logic          hold_r;
   logic [CW-1:0] cnt_r;

   assign hold_out = hold_r;

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         hold_r <= 1'b1;
         cnt_r  <= '0;
      end else if (trigger_in) begin
         hold_r <= 1'b1;
         cnt_r  <= '0;
      end else if (hold_r) begin
         hold_r <= (cnt_r != CW'(CYCLES - 1));
         cnt_r  <= cnt_r + 1'b1;
      end
   end
endmodule

// *** src/dwd_top.sv ***
// digital watchdog downcounter with its control register and stop control
// Summary of operation
// - counter decrements while active; chip reset when it runs out unless reloaded
// - reset fires when counter bit 6 falls; upper six bits set period
// - software option: inactive after reset until a one is written to bit 0
// - once active, clearing the activation bit is ignored until chip reset
// - hardware option: activation bit reads one, writes ignored, always active
// - hardware option without external stop control: STOP becomes WAIT
// - external stop control: STOP is WAIT if active and NMI low, true frozen STOP if NMI high or inactive
// - leaving STOP on an interrupt resumes counting from the held value
// - reset loads register 0FEh (software option, inactive) or 0FFh (hardware option); self-reset and period bits all one
// - writing the self-reset bit to zero while active or activating forces an immediate chip reset
// - period bits map reversed: register bit 7 is counter LSB
// - six period bits choose 64 timeouts of 3072 to 196608 cycles
// - while inactive the counter is a free 7-bit down timer
// - at least 28 instructions run after activation or reset before timeout
// - writing a count reloads the counter; software must reload periodically
// - with interrupts globally disabled NMI cannot wake from STOP or WAIT
// - watchdog reset restarts chip like the reset pin, with stabilisation delay
`timescale 1ns/100ps
module dwd_top
   import dwd_pkg::*;
#(
   parameter bit HW_ACTIVATION = 1'b1,
   parameter bit EXT_STOP_CTRL = 1'b0,
   parameter int STAB_CYCLES   = DWD_STAB_CYCLES
) (
   input  wire logic       SYS_CLK_IN,
   input  wire logic       RESETN_IN,
   input  wire logic [7:0] REG_ADDR_IN,
   input  wire logic [7:0] REG_WDATA_IN,
   input  wire logic       REG_WR_IN,
   input  wire logic       REG_RD_IN,
   input  wire logic       STOP_INSTR_IN,
   input  wire logic       NMI_PIN_IN,
   input  wire logic       NMI_REQ_IN,
   input  wire logic       IRQ_REQ_IN,
   input  wire logic       GLOBAL_IRQ_ENABLE_IN,
   output logic [7:0]      REG_RDATA_OUT,
   output logic            CHIP_RESET_OUT,
   output logic            WDG_ACTIVE_OUT,
   output logic            WAIT_MODE_OUT,
   output logic            STOP_MODE_OUT
);
   localparam logic ACT_RESET = HW_ACTIVATION;

   // register image of the counter: bit 7-i is counter bit i, bit 1 is the top bit
   function automatic logic [7:0] cnt_to_reg(input logic [6:0] cnt, input logic act);
      logic [7:0] r;
      r = '0;
      for (int i = 0; i < DWD_PERIOD_W; i++) begin
         r[7-i] = cnt[i];
      end
      r[DWD_SR_BIT]  = cnt[DWD_CNT_W-1];
      r[DWD_ACT_BIT] = act;
      return r;
   endfunction

   function automatic logic [6:0] reg_to_cnt(input logic [7:0] r);
      logic [6:0] c;
      c = '0;
      for (int i = 0; i < DWD_PERIOD_W; i++) begin
         c[i] = r[7-i];
      end
      c[DWD_CNT_W-1] = r[DWD_SR_BIT];
      return c;
   endfunction

   dwd_bus_t   bus;
   logic [6:0] cnt_r;
   logic [6:0] cnt_nxt;
   logic       act_r;
   logic       act_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   dwd_pwr_t   pwr_r;
   dwd_pwr_t   pwr_nxt;
   logic       tick;
   logic       hold;

   assign bus.addr  = REG_ADDR_IN;
   assign bus.wdata = REG_WDATA_IN;
   assign bus.wr    = REG_WR_IN;
   assign bus.rd    = REG_RD_IN;

   wire wr_hit     = bus.wr & (bus.addr == DWD_REG_OFFSET) & ~hold;
   wire rd_hit     = bus.rd & (bus.addr == DWD_REG_OFFSET);
   wire cnt_run    = (pwr_r != DWD_STOP);
   // a set activation bit is sticky; under the hardware option it is fixed at one
   assign act_nxt  = HW_ACTIVATION | act_r | (wr_hit & bus.wdata[DWD_ACT_BIT]);
   wire sr_clr_rst = wr_hit & act_nxt & ~bus.wdata[DWD_SR_BIT];
   wire timeout    = tick & cnt_run & act_r & ~wr_hit & (cnt_r == DWD_CNT_SR_EDGE);
   wire wd_rst     = sr_clr_rst | timeout;
   wire stop_wait  = act_r & (~EXT_STOP_CTRL | ~NMI_PIN_IN);
   wire wake       = GLOBAL_IRQ_ENABLE_IN & (IRQ_REQ_IN | NMI_REQ_IN);

   // restarting the prescaler on every reload gives a full first step
   dwd_prescaler #(
      .DIV_A      (DWD_PRE_DIV_A),
      .DIV_B      (DWD_PRE_DIV_B)
   ) u_presc (
      .clk_in     (SYS_CLK_IN),
      .resetn_in  (RESETN_IN),
      .restart_in (wr_hit | hold),
      .tick_out   (tick)
   );

   dwd_stab_delay #(
      .CYCLES     (STAB_CYCLES)
   ) u_stab (
      .clk_in     (SYS_CLK_IN),
      .resetn_in  (RESETN_IN),
      .trigger_in (wd_rst),
      .hold_out   (hold)
   );

   // counter next value: reload beats decrement, stop freezes it
   always_comb begin
      if (hold) begin
         cnt_nxt = DWD_CNT_RESET;
      end else if (wr_hit) begin
         cnt_nxt = reg_to_cnt(bus.wdata);
      end else if (tick & cnt_run) begin
         cnt_nxt = cnt_r - 7'h01;
      end else begin
         cnt_nxt = cnt_r;
      end
   end

   assign rdata_nxt = rd_hit ? cnt_to_reg(cnt_r, act_r) : 8'h00;

   always_comb begin
      pwr_nxt = pwr_r;
      case (pwr_r)
         DWD_RUN: begin
            if (STOP_INSTR_IN) begin
               pwr_nxt = stop_wait ? DWD_WAIT : DWD_STOP;
            end
         end
         DWD_WAIT, DWD_STOP: begin
            if (wake) begin
               pwr_nxt = DWD_RUN;
            end
         end
         default: pwr_nxt = DWD_RUN;
      endcase
   end

   always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         cnt_r   <= DWD_CNT_RESET;
         act_r   <= ACT_RESET;
         rdata_r <= 8'h00;
         pwr_r   <= DWD_RUN;
      end else begin
         cnt_r   <= cnt_nxt;
         act_r   <= hold ? ACT_RESET : act_nxt;
         rdata_r <= rdata_nxt;
         pwr_r   <= hold ? DWD_RUN : pwr_nxt;
      end
   end

   assign REG_RDATA_OUT  = rdata_r;
   assign CHIP_RESET_OUT = hold;
   assign WDG_ACTIVE_OUT = act_r;
   assign WAIT_MODE_OUT  = (pwr_r == DWD_WAIT);
   assign STOP_MODE_OUT  = (pwr_r == DWD_STOP);

   default clocking cb @(posedge SYS_CLK_IN);
   endclocking
   default disable iff (!RESETN_IN);

   sequence s_hold_8;
      CHIP_RESET_OUT [*8];
   endsequence

   sequence s_no_tick_8;
      !tick [*8];
   endsequence

   a_timeout_reset: assert property (
      (tick && act_r && !hold && pwr_r != DWD_STOP && !wr_hit && cnt_r == 7'h40)
      |=> s_hold_8)
      else $error("counter ran out without chip reset");

   a_sr_write_reset: assert property (
      (wr_hit && act_nxt && !bus.wdata[1]) |=> s_hold_8)
      else $error("self-reset write did not reset chip");

   a_act_sticky: assert property (
      (act_r && !hold) |=> act_r)
      else $error("activation bit cleared while running");

   a_sw_stays_off: assert property (
      (!act_r && !(wr_hit && bus.wdata[0])) |=> !act_r)
      else $error("watchdog activated without a write");

   a_hw_always_on: assert property (
      !HW_ACTIVATION || act_r)
      else $error("hardware option watchdog not active");

   a_reset_value: assert property (
      $fell(CHIP_RESET_OUT) |-> (cnt_r == 7'h7F && act_r == HW_ACTIVATION))
      else $error("register not at reset value after reset");

   a_reload_count: assert property (
      wr_hit |=> (cnt_r == reg_to_cnt($past(bus.wdata)) || CHIP_RESET_OUT))
      else $error("write did not reload counter");

   a_read_reversed: assert property (
      rd_hit |=> REG_RDATA_OUT == {$past(cnt_r[0]), $past(cnt_r[1]), $past(cnt_r[2]),
                                   $past(cnt_r[3]), $past(cnt_r[4]), $past(cnt_r[5]),
                                   $past(cnt_r[6]), $past(act_r)})
      else $error("read value not in reversed order");

   a_stop_freeze: assert property (
      (pwr_r == DWD_STOP && !wr_hit && !hold) |=> $stable(cnt_r))
      else $error("counter moved in stop mode");

   a_stop_as_wait: assert property (
      (pwr_r == DWD_RUN && STOP_INSTR_IN && act_r && !NMI_PIN_IN && !hold)
      |=> pwr_r == DWD_WAIT)
      else $error("stop instruction not taken as wait");

   a_wake_resume: assert property (
      (pwr_r == DWD_STOP && wake && !hold) |=> pwr_r == DWD_RUN ##1 cnt_run)
      else $error("interrupt did not resume counting");

   a_no_gen_wake: assert property (
      (pwr_r != DWD_RUN && !GLOBAL_IRQ_ENABLE_IN && !hold) |=> pwr_r != DWD_RUN)
      else $error("woke with interrupts globally disabled");

   a_free_timer_wrap: assert property (
      (!act_r && tick && cnt_run && !wr_hit && !hold && cnt_r == 7'h00) |=> cnt_r == 7'h7F)
      else $error("free timer did not wrap");

   a_tick_spacing: assert property (
      (tick || wr_hit) |=> s_no_tick_8)
      else $error("prescaler tick too soon");
endmodule

// *** tb/dwd_cpu_model.sv ***
// cpu core model driving the watchdog register port and stop requests
`timescale 1ns/100ps
module dwd_cpu_model
   import dwd_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic [7:0] rdata_in,
   output logic [7:0]      addr_out,
   output logic [7:0]      wdata_out,
   output logic            wr_out,
   output logic            rd_out,
   output logic            stop_out
);
   initial begin
      addr_out  = 8'h00;
      wdata_out = 8'h00;
      wr_out    = 1'h0;
      rd_out    = 1'h0;
      stop_out  = 1'h0;
   end
   // fresh counts written in time keep the chip out of reset
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_out  <= a;
      wdata_out <= d;
      wr_out    <= 1'h1;
      @(posedge clk_in);
      wr_out    <= 1'h0;
      addr_out  <= ~a;
      wdata_out <= ~d;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_in);
      addr_out <= a;
      rd_out   <= 1'h1;
      @(posedge clk_in);
      rd_out   <= 1'h0;
      addr_out <= ~a;
      #1 d = rdata_in;
   endtask
   task automatic stop_pulse();
      @(posedge clk_in);
      stop_out <= 1'h1;
      @(posedge clk_in);
      stop_out <= 1'h0;
   endtask
endmodule

// *** tb/testbench.sv ***
// self-checking bench of the watchdog with external stop control
`timescale 1ns/100ps
module testbench
   import dwd_pkg::*;
;
   logic       clk = 0, resetn = 0, wr, rd, stop;
   logic       nmi_pin = 0, nmi_req = 0, irq_req = 0, gie = 0;
   logic [7:0] addr, wdata, rdata, d;
   logic       chip_reset, wdg_active, wait_mode, stop_mode;
   int         n_fail = 0, check_count = 0, cycles = 0, n;
   always #10 clk = ~clk;
   dwd_top #(.HW_ACTIVATION(1'h1), .EXT_STOP_CTRL(1'h1), .STAB_CYCLES(16)) dwd_top_i (
      .SYS_CLK_IN(clk), .RESETN_IN(resetn), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
      .REG_WR_IN(wr), .REG_RD_IN(rd), .STOP_INSTR_IN(stop), .NMI_PIN_IN(nmi_pin),
      .NMI_REQ_IN(nmi_req), .IRQ_REQ_IN(irq_req), .GLOBAL_IRQ_ENABLE_IN(gie),
      .REG_RDATA_OUT(rdata), .CHIP_RESET_OUT(chip_reset), .WDG_ACTIVE_OUT(wdg_active),
      .WAIT_MODE_OUT(wait_mode), .STOP_MODE_OUT(stop_mode));
   dwd_cpu_model dwd_cpu_model_i (
      .clk_in(clk), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
      .wr_out(wr), .rd_out(rd), .stop_out(stop));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic hold_end(input int exp_len);
      for (n = 0; n < 200 && chip_reset !== 1'h0; n++) begin
         @(posedge clk);
         #1;
      end
      if (exp_len > 0) chk(n[7:0], exp_len[7:0]);
      #1 dwd_cpu_model_i.rd_reg(DWD_REG_OFFSET, d);
      chk(d, 8'hFF);
      chk({7'h0, wdg_active}, 8'h01);
   endtask
   task automatic t_map();
      dwd_cpu_model_i.wr_reg(DWD_REG_OFFSET, 8'h86);
      dwd_cpu_model_i.rd_reg(DWD_REG_OFFSET, d);
      chk(d, 8'h87);
      dwd_cpu_model_i.rd_reg(8'hD9, d);
      chk(d, 8'h00);
   endtask
   task automatic t_timeout();
      repeat (2) begin
         dwd_cpu_model_i.wr_reg(DWD_REG_OFFSET, 8'h83);
         repeat (5000) @(posedge clk);
         chk({7'h0, chip_reset}, 8'h00);
      end
      dwd_cpu_model_i.wr_reg(DWD_REG_OFFSET, 8'h83);
      for (n = 0; n < 7000 && chip_reset !== 1'h1; n++) begin
         @(posedge clk);
         #1;
      end
      chk({7'h0, n >= 6143 && n <= 6147}, 8'h01);
      hold_end(16);
   endtask
   task automatic t_sr();
      dwd_cpu_model_i.wr_reg(DWD_REG_OFFSET, 8'hFD);
      #1 chk({7'h0, chip_reset}, 8'h01);
      hold_end(16);
   endtask
   task automatic wake();
      @(posedge clk);
      gie     <= 1'h1;
      irq_req <= 1'h1;
      @(posedge clk);
      irq_req <= 1'h0;
      #1 chk({6'h0, wait_mode, stop_mode}, 8'h00);
   endtask
   task automatic t_stop();
      dwd_cpu_model_i.wr_reg(DWD_REG_OFFSET, 8'hFF);
      nmi_pin <= 1'h1;
      dwd_cpu_model_i.stop_pulse();
      #1 chk({6'h0, wait_mode, stop_mode}, 8'h01);
      repeat (3100) @(posedge clk);
      dwd_cpu_model_i.rd_reg(DWD_REG_OFFSET, d);
      chk(d, 8'hFF);
      @(posedge clk);
      nmi_req <= 1'h1;
      repeat (5) @(posedge clk);
      nmi_req <= 1'h0;
      #1 chk({7'h0, stop_mode}, 8'h01);
      wake();
      repeat (3100) @(posedge clk);
      dwd_cpu_model_i.rd_reg(DWD_REG_OFFSET, d);
      chk(d, 8'h7F);
   endtask
   task automatic t_wait();
      dwd_cpu_model_i.wr_reg(DWD_REG_OFFSET, 8'hFF);
      nmi_pin <= 1'h0;
      gie     <= 1'h0;
      dwd_cpu_model_i.stop_pulse();
      #1 chk({6'h0, wait_mode, stop_mode}, 8'h02);
      wake();
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         n_fail++;
         finish_test();
      end
   end
   initial begin
      repeat (10) @(posedge clk);
      resetn <= 1'h1;
      hold_end(16);
      t_map();
      t_timeout();
      t_sr();
      t_stop();
      t_wait();
      finish_test();
   end
endmodule
